// >>> design/bwsd_pkg.sv
package bwsd_pkg;

  // Transfer size code as carried on the bus
  typedef enum logic [1:0] {
    BWSD_SIZE_LONG = 2'h0,
    BWSD_SIZE_BYTE = 2'h1,
    BWSD_SIZE_WORD = 2'h2,
    BWSD_SIZE_LINE = 2'h3
  } bwsd_size_t;

  // Port width code of the target region; both 1x codes mean a 16-bit port
  typedef enum logic [1:0] {
    BWSD_PORT_32  = 2'h0,
    BWSD_PORT_8   = 2'h1,
    BWSD_PORT_16  = 2'h2,
    BWSD_PORT_16B = 2'h3
  } bwsd_port_t;

  // Function of one shared pin, two bits per pin
  typedef enum logic [1:0] {
    BWSD_FN_STROBE = 2'h0,
    BWSD_FN_ADDR   = 2'h1,
    BWSD_FN_CS     = 2'h2,
    BWSD_FN_RSVD   = 2'h3
  } bwsd_fn_t;

  localparam int unsigned BWSD_NUM_PINS = 4;
  localparam int unsigned BWSD_FN_W     = 2;
  localparam int unsigned BWSD_PFS_W    = BWSD_NUM_PINS * BWSD_FN_W;
  // Every pin a write strobe after reset
  localparam logic [7:0]  BWSD_PFS_RESET = 8'h00;
  // Lowest upper address bit and lowest upper chip select on the shared pins
  localparam int unsigned BWSD_ADDR_BASE = 24;
  localparam int unsigned BWSD_CS_BASE   = 4;

  // Lane enable masks, bit i is strobe i (strobe 0 carries the top data byte)
  localparam logic [3:0] BWSD_LANE_NONE = 4'h0;
  localparam logic [3:0] BWSD_LANE_0    = 4'h1;
  localparam logic [3:0] BWSD_LANE_1    = 4'h2;
  localparam logic [3:0] BWSD_LANE_01   = 4'h3;
  localparam logic [3:0] BWSD_LANE_23   = 4'hc;
  localparam logic [3:0] BWSD_LANE_ALL  = 4'hf;

  typedef struct packed {
    logic       valid;
    logic       write;
    bwsd_size_t size;
    logic [1:0] addr_lo;
    bwsd_port_t port;
    logic       burst;
  } bwsd_xfer_t;

endpackage : bwsd_pkg

// >>> design/bwsd_lane_dec.sv
`timescale 1ns/1ps
`default_nettype none
module bwsd_lane_dec
  import bwsd_pkg::*;
(
  // Transfer attributes
  input  wire bwsd_xfer_t xfer_in,
  // Active-high lane enables
  output logic [3:0]      lane_en_out
);

  // Burst capability never changes the lane pattern; it is carried for completeness
  always_comb begin
    lane_en_out = BWSD_LANE_NONE;
    case (xfer_in.port)
      BWSD_PORT_8: begin
        lane_en_out = BWSD_LANE_0;
      end
      BWSD_PORT_16, BWSD_PORT_16B: begin
        if (xfer_in.size == BWSD_SIZE_BYTE) begin
          lane_en_out = xfer_in.addr_lo[0] ? BWSD_LANE_1 : BWSD_LANE_0;
        end else begin
          lane_en_out = BWSD_LANE_01;
        end
      end
      BWSD_PORT_32: begin
        case (xfer_in.size)
          BWSD_SIZE_BYTE: lane_en_out = 4'(BWSD_LANE_0 << xfer_in.addr_lo);
          BWSD_SIZE_WORD: lane_en_out = xfer_in.addr_lo[1] ? BWSD_LANE_23 : BWSD_LANE_01;
          default:        lane_en_out = BWSD_LANE_ALL;
        endcase
      end
      default: lane_en_out = BWSD_LANE_NONE;
    endcase
  end

endmodule : bwsd_lane_dec
`default_nettype wire

// >>> design/bwsd_top.sv
`timescale 1ns/1ps
`default_nettype none
module bwsd_top
  import bwsd_pkg::*;
(
  // Clock and reset
  input  wire logic       CORE_CLK_IN,
  input  wire logic       RST_N_IN,
  // Pin function setup
  input  wire logic       PIN_FUNC_LOAD_IN,
  input  wire logic [7:0] PIN_FUNC_DATA_IN,
  output logic      [7:0] PIN_FUNC_OUT,
  // Current transfer
  input  wire logic       XFER_VALID_IN,
  input  wire logic       XFER_WRITE_IN,
  input  wire logic [1:0] XFER_SIZE_IN,
  input  wire logic [1:0] XFER_ADDR_LO_IN,
  input  wire logic [1:0] XFER_PORT_IN,
  input  wire logic       XFER_BURST_IN,
  // Sources for the other pin functions
  input  wire logic [3:0] UPPER_ADDR_IN,
  input  wire logic [3:0] UPPER_CS_N_IN,
  // Shared pins
  output logic      [3:0] SHARED_PIN_OUT
);

  logic [7:0] pin_function_select_reg_r;
  bwsd_xfer_t xfer;
  logic [3:0] lane_en;
  logic [3:0] strobe_n;
  logic       wr_active;

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pin_function_select_reg_r <= BWSD_PFS_RESET;
    end else if (PIN_FUNC_LOAD_IN) begin
      pin_function_select_reg_r <= PIN_FUNC_DATA_IN;
    end
  end

  assign PIN_FUNC_OUT = pin_function_select_reg_r;

  always_comb begin
    xfer.valid   = XFER_VALID_IN;
    xfer.write   = XFER_WRITE_IN;
    xfer.size    = bwsd_size_t'(XFER_SIZE_IN);
    xfer.addr_lo = XFER_ADDR_LO_IN;
    xfer.port    = bwsd_port_t'(XFER_PORT_IN);
    xfer.burst   = XFER_BURST_IN;
  end

  bwsd_lane_dec u_lane_dec (
    .xfer_in     (xfer),
    .lane_en_out (lane_en)
  );

  // Kept combinational so the strobes line up with the address in the same cycle
  assign wr_active = xfer.valid && xfer.write;
  assign strobe_n  = wr_active ? ~lane_en : BWSD_LANE_ALL;

  // Pin i carries strobe i, so strobe 0 lands on the pin that qualifies D31-D24
  always_comb begin
    for (int i = 0; i < BWSD_NUM_PINS; i++) begin
      case (bwsd_fn_t'(pin_function_select_reg_r[i*BWSD_FN_W +: BWSD_FN_W]))
        BWSD_FN_STROBE: SHARED_PIN_OUT[i] = strobe_n[i];
        BWSD_FN_ADDR:   SHARED_PIN_OUT[i] = UPPER_ADDR_IN[i];
        BWSD_FN_CS:     SHARED_PIN_OUT[i] = UPPER_CS_N_IN[i];
        // Reserved code parks the pin inactive rather than leaving a stray strobe
        default:        SHARED_PIN_OUT[i] = 1'b1;
      endcase
    end
  end

  // Helper terms for the checks below
  logic       all_strobe;
  logic [3:0] exp_lane;
  assign all_strobe = (pin_function_select_reg_r == BWSD_PFS_RESET);

  always_comb begin
    exp_lane = BWSD_LANE_NONE;
    if (XFER_PORT_IN == 2'h1) begin
      exp_lane = 4'h1;
    end else if (XFER_PORT_IN[1]) begin
      exp_lane = (XFER_SIZE_IN != 2'h1) ? 4'h3 : (XFER_ADDR_LO_IN[0] ? 4'h2 : 4'h1);
    end else if (XFER_SIZE_IN == 2'h1) begin
      exp_lane = 4'(4'h1 << XFER_ADDR_LO_IN);
    end else if (XFER_SIZE_IN == 2'h2) begin
      exp_lane = XFER_ADDR_LO_IN[1] ? 4'hc : 4'h3;
    end else begin
      exp_lane = 4'hf;
    end
  end

  chk_reset_strobe_fn: assert property (
    @(posedge CORE_CLK_IN)
    $rose(RST_N_IN) |-> (pin_function_select_reg_r == 8'h00)
  ) else $error("pin functions not all strobe after reset");

  chk_func_load_takes: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    PIN_FUNC_LOAD_IN |=> (PIN_FUNC_OUT == $past(PIN_FUNC_DATA_IN))
  ) else $error("pin function load not taken");

  chk_idle_negated: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (all_strobe && !(XFER_VALID_IN && XFER_WRITE_IN)) |-> (SHARED_PIN_OUT == 4'hf)
  ) else $error("strobe asserted outside a write");

  chk_lane_decode: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (all_strobe && XFER_VALID_IN && XFER_WRITE_IN) |-> (SHARED_PIN_OUT == ~exp_lane)
  ) else $error("strobe pattern wrong for transfer");

  chk_port8_lane0: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (all_strobe && XFER_VALID_IN && XFER_WRITE_IN && XFER_PORT_IN == 2'h1)
      |-> (SHARED_PIN_OUT == 4'he)
  ) else $error("8-bit port strobe wrong");

  chk_port16_pair: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (all_strobe && XFER_VALID_IN && XFER_WRITE_IN && XFER_PORT_IN[1])
      |-> (SHARED_PIN_OUT[3:2] == 2'h3 && SHARED_PIN_OUT[1:0] != 2'h3)
  ) else $error("16-bit port used upper strobes");

  chk_port32_byte: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (all_strobe && XFER_VALID_IN && XFER_WRITE_IN && XFER_PORT_IN == 2'h0
      && XFER_SIZE_IN == 2'h1) |-> !SHARED_PIN_OUT[XFER_ADDR_LO_IN]
  ) else $error("32-bit byte strobe on wrong lane");

  chk_port32_full: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (all_strobe && XFER_VALID_IN && XFER_WRITE_IN && XFER_PORT_IN == 2'h0
      && (XFER_SIZE_IN == 2'h0 || XFER_SIZE_IN == 2'h3)) |-> (SHARED_PIN_OUT == 4'h0)
  ) else $error("32-bit longword or line missing strobes");

  chk_other_fn_route: assert property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    (pin_function_select_reg_r[1:0] == 2'h1 |-> SHARED_PIN_OUT[0] == UPPER_ADDR_IN[0])
    and (pin_function_select_reg_r[3:2] == 2'h2 |-> SHARED_PIN_OUT[1] == UPPER_CS_N_IN[1])
  ) else $error("address or chip select routing wrong");

  cov_word32_high: cover property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    all_strobe && XFER_VALID_IN && XFER_WRITE_IN && XFER_PORT_IN == 2'h0
      && XFER_SIZE_IN == 2'h2 && XFER_ADDR_LO_IN[1]
  );

  cov_byte16_odd: cover property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    all_strobe && XFER_VALID_IN && XFER_WRITE_IN && XFER_PORT_IN[1]
      && XFER_SIZE_IN == 2'h1 && XFER_ADDR_LO_IN[0]
  );

  cov_reprogram: cover property (
    @(posedge CORE_CLK_IN) disable iff (!RST_N_IN)
    PIN_FUNC_LOAD_IN ##1 (pin_function_select_reg_r != 8'h00)
  );

endmodule : bwsd_top
`default_nettype wire

// >>> tb/bwsd_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module bwsd_mem_model (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // Memory side of the bus
  input  wire logic [3:0]  we_n_in,
  input  wire logic [31:0] data_in,
  output logic      [31:0] mem_out
);
  // Byte lanes land at the edge, as in a synchronous memory
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_out <= 32'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (!we_n_in[i]) mem_out[31-8*i -: 8] <= data_in[31-8*i -: 8];
      end
    end
  end
endmodule : bwsd_mem_model
`default_nettype wire

// >>> tb/tb_byte_write_strobe_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_byte_write_strobe_decoder;
  import bwsd_pkg::*;
  logic clk = 0, rst_n = 0, ld = 0, v = 0, w = 0, b = 0;
  logic [1:0] s = 0, a = 0, p = 0;
  logic [7:0] ld_d = 0;
  logic [3:0] ua = 4'h5, uc = 4'ha;
  logic [31:0] dat = 0;
  wire logic [7:0] pfo;
  wire logic [3:0] pins;
  wire logic [31:0] mem;
  int fail_count = 0, compares = 0, cyc = 0;
  always #2 clk = ~clk;
  bwsd_top dut (.CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PIN_FUNC_LOAD_IN(ld),
    .PIN_FUNC_DATA_IN(ld_d), .PIN_FUNC_OUT(pfo), .XFER_VALID_IN(v), .XFER_WRITE_IN(w),
    .XFER_SIZE_IN(s), .XFER_ADDR_LO_IN(a), .XFER_PORT_IN(p), .XFER_BURST_IN(b),
    .UPPER_ADDR_IN(ua), .UPPER_CS_N_IN(uc), .SHARED_PIN_OUT(pins));
  bwsd_mem_model mdl (.clk_in(clk), .rst_n_in(rst_n), .we_n_in(pins), .data_in(dat),
    .mem_out(mem));
  task automatic complete_run();
    $display("fail_count=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check
  task automatic xfer(input logic vv, ww, input int ss, aa, pp, input logic bb);
    @(posedge clk);
    v <= vv; w <= ww; s <= 2'(ss); a <= 2'(aa); p <= 2'(pp); b <= bb;
    #1;
  endtask : xfer
  task automatic load(input logic [7:0] d);
    @(posedge clk);
    ld <= 1'b1; ld_d <= d;
    @(posedge clk);
    ld <= 1'b0;
    #1;
  endtask : load
  // Own lane model, bit i is strobe i
  function automatic logic [3:0] lanes(input int pp, ss, aa);
    if (pp == 1) return 4'h1;
    if (pp >= 2) return (ss == 1) ? ((aa % 2) ? 4'h2 : 4'h1) : 4'h3;
    if (ss == 1) return 4'h1 << aa;
    if (ss == 2) return (aa >= 2) ? 4'hc : 4'h3;
    return 4'hf;
  endfunction : lanes
  task automatic t_reset();
    check(pfo, 8'h00, "reset function");
    check(pins, 4'hf, "idle pins");
  endtask : t_reset
  task automatic t_table();
    logic [3:0] exp_n;
    for (int pp = 0; pp < 4; pp++) begin
      for (int ss = 0; ss < 4; ss++) begin
        for (int aa = 0; aa < 4; aa++) begin
          for (int bb = 0; bb < 2; bb++) begin
            xfer(1, 1, ss, aa, pp, bb[0]);
            // Invert at 4 bits so the widened compare sees no stray upper ones
            exp_n = ~lanes(pp, ss, aa);
            check(pins, exp_n, "write lanes");
            xfer(1, 0, ss, aa, pp, bb[0]);
            check(pins, 4'hf, "read strobes");
            xfer(0, 1, ss, aa, pp, bb[0]);
            check(pins, 4'hf, "idle strobes");
          end
        end
      end
    end
  endtask : t_table
  task automatic t_lanes();
    for (int aa = 0; aa < 4; aa++) begin
      // Data rides with its own strobe; the model takes both at the next edge
      xfer(1, 1, 1, aa, 0, 1'b0);
      dat <= {4{8'(8'h10 + aa)}};
    end
    xfer(0, 0, 0, 0, 0, 1'b0);
    check(mem, 32'h10111213, "byte lane order");
  endtask : t_lanes
  task automatic t_func();
    load(8'h55);
    check(pins, ua, "address function");
    load(8'haa);
    xfer(1, 1, 0, 0, 0, 1'b0);
    check(pins, uc, "chip select function");
    load(8'he4);
    check(pfo, 8'he4, "function readback");
    check(pins, 4'h8, "mixed functions");
    xfer(0, 0, 0, 0, 0, 1'b0);
  endtask : t_func
  task automatic t_midreset();
    load(8'hff);
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    check(pfo, 8'h00, "reset in mid run");
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    xfer(1, 1, 0, 0, 0, 1'b1);
    check(pins, 4'h0, "strobes after reset");
  endtask : t_midreset
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    t_reset();
    @(posedge clk);
    rst_n <= 1'b1;
    t_table();
    t_lanes();
    t_func();
    t_midreset();
    complete_run();
  end
endmodule : tb_byte_write_strobe_decoder
`default_nettype wire
